// ==== verilog/timer8_pkg.sv ====
// Package with register map, field positions and mode codes of the 8-bit waveform timer.
`default_nettype none
package timer8_pkg;
	localparam logic [2:0] ADDR_CTRL_A = 3'h0;
	localparam logic [2:0] ADDR_CTRL_B = 3'h1;
	localparam logic [2:0] ADDR_COUNT = 3'h2;
	localparam logic [2:0] ADDR_CMP_A = 3'h3;
	localparam logic [2:0] ADDR_CMP_B = 3'h4;
	localparam logic [2:0] ADDR_STATUS = 3'h5;
	localparam logic [2:0] ADDR_MASK = 3'h6;
	localparam logic [2:0] ADDR_DIR = 3'h7;
	localparam int CHA_MODE_HI = 7;
	localparam int CHA_MODE_LO = 6;
	localparam int CHB_MODE_HI = 5;
	localparam int CHB_MODE_LO = 4;
	localparam int CTRL_B_MODE_HIGH_BIT = 3;
	localparam int CTRL_B_TICK_ENABLE = 0;
	localparam logic [7:0] CTRL_A_WRITE_MASK = 8'hf3;
	localparam logic [7:0] CTRL_B_WRITE_MASK = 8'h09;
	localparam logic [7:0] RESET_BYTE = 8'h00;
	localparam logic [7:0] MAX_VALUE = 8'hff;
	localparam logic [7:0] BOTTOM_VALUE = 8'h00;
	localparam int EVT_OVERFLOW = 0;
	localparam int EVT_MATCH_A = 1;
	localparam int EVT_MATCH_B = 2;
	localparam logic [2:0] MODE_NORMAL = 3'h0;
	localparam logic [2:0] MODE_PC_FF = 3'h1;
	localparam logic [2:0] MODE_CLEAR_ON_MATCH = 3'h2;
	localparam logic [2:0] MODE_FAST_FF = 3'h3;
	localparam logic [2:0] MODE_PC_CMP = 3'h5;
	localparam logic [2:0] MODE_FAST_CMP = 3'h7;
	localparam logic [1:0] OUT_OFF = 2'h0;
	localparam logic [1:0] OUT_TOGGLE = 2'h1;
	localparam logic [1:0] OUT_CLEAR = 2'h2;
	localparam logic [1:0] OUT_SET = 2'h3;
endpackage : timer8_pkg
`default_nettype wire

// ==== verilog/timer8_waveform_output_control.sv ====
// 8-bit timer with waveform modes, two compare outputs and register port.
`timescale 1ns/1ps
`default_nettype none
module timer8_waveform_output_control (
	input wire logic mclk,
	input wire logic rst,
	input wire logic [2:0] addr,
	input wire logic [7:0] wdata,
	input wire logic wr,
	input wire logic rd,
	input wire logic timer_tick,
	output logic [7:0] rdata,
	output logic chan_a_compare_pin,
	output logic chan_a_compare_pin_oe_n,
	output logic chan_b_compare_pin,
	output logic chan_b_compare_pin_oe_n,
	output logic irq
);
	logic [7:0] waveform_control_a;
	logic [7:0] waveform_control_b;
	logic [7:0] counter_value;
	logic [7:0] chan_a_compare_value;
	logic [7:0] chan_b_compare_value;
	logic [7:0] cmp_buf_a;
	logic [7:0] cmp_buf_b;
	logic [2:0] status;
	logic [2:0] mask;
	logic [1:0] pin_dir;
	logic count_down;
	logic [1:0] wave_out;
	logic [1:0] match_block;
	logic [2:0] waveform_mode_select;
	logic [7:0] top;
	logic fast_pwm;
	logic phase_pwm;
	logic non_pwm;
	logic tick;
	logic at_top;
	logic at_bottom;
	logic [7:0] next_count;
	logic next_down;
	logic [2:0] events;
	logic [1:0] mode_a;
	logic [1:0] mode_b;

	////////////////////////////////////////////////////////////////////////////
	assign waveform_mode_select = {waveform_control_b[timer8_pkg::CTRL_B_MODE_HIGH_BIT],
		waveform_control_a[1:0]};
	assign mode_a = waveform_control_a[timer8_pkg::CHA_MODE_HI:timer8_pkg::CHA_MODE_LO];
	assign mode_b = waveform_control_a[timer8_pkg::CHB_MODE_HI:timer8_pkg::CHB_MODE_LO];
	assign tick = timer_tick & waveform_control_b[timer8_pkg::CTRL_B_TICK_ENABLE];
	// Reserved modes 4 and 6 fall into none of the classes and leave the counter idle.
	assign fast_pwm = (waveform_mode_select == timer8_pkg::MODE_FAST_FF)
		|| (waveform_mode_select == timer8_pkg::MODE_FAST_CMP);
	assign phase_pwm = (waveform_mode_select == timer8_pkg::MODE_PC_FF)
		|| (waveform_mode_select == timer8_pkg::MODE_PC_CMP);
	assign non_pwm = (waveform_mode_select == timer8_pkg::MODE_NORMAL)
		|| (waveform_mode_select == timer8_pkg::MODE_CLEAR_ON_MATCH);

	always_comb
	begin
		case (waveform_mode_select)
			timer8_pkg::MODE_CLEAR_ON_MATCH, timer8_pkg::MODE_PC_CMP,
			timer8_pkg::MODE_FAST_CMP: top = chan_a_compare_value;
			default: top = timer8_pkg::MAX_VALUE;
		endcase
	end

	assign at_top = (counter_value == top);
	assign at_bottom = (counter_value == timer8_pkg::BOTTOM_VALUE);

	////////////////////////////////////////////////////////////////////////////
	always_comb
	begin
		next_count = counter_value;
		next_down = count_down;
		events = 3'h0;
		if (phase_pwm)
		begin
			// The count holds TOP for one tick; direction flips on the tick that steps down from TOP.
			if (!count_down)
			begin
				if (at_top)
				begin
					next_down = 1'b1;
					next_count = counter_value - 8'h01;
				end
				else
				begin
					next_count = counter_value + 8'h01;
				end
			end
			else if (at_bottom)
			begin
				next_down = 1'b0;
				next_count = counter_value + 8'h01;
				events[timer8_pkg::EVT_OVERFLOW] = 1'b1;
			end
			else
			begin
				next_count = counter_value - 8'h01;
			end
		end
		else if (fast_pwm || non_pwm)
		begin
			next_down = 1'b0;
			if (at_top)
			begin
				next_count = timer8_pkg::BOTTOM_VALUE;
			end
			else
			begin
				next_count = counter_value + 8'h01;
			end
			if (waveform_mode_select == timer8_pkg::MODE_FAST_CMP)
			begin
				events[timer8_pkg::EVT_OVERFLOW] = at_top;
			end
			else
			begin
				events[timer8_pkg::EVT_OVERFLOW] = (counter_value == timer8_pkg::MAX_VALUE);
			end
		end
		events[timer8_pkg::EVT_MATCH_A] = (counter_value == chan_a_compare_value) & ~match_block[0];
		events[timer8_pkg::EVT_MATCH_B] = (counter_value == chan_b_compare_value) & ~match_block[1];
	end

	////////////////////////////////////////////////////////////////////////////
	// Counter, direction and compare-match blocking after a counter write.
	always_ff @(posedge mclk)
	begin
		if (rst)
		begin
			counter_value <= timer8_pkg::RESET_BYTE;
			count_down <= 1'b0;
			match_block <= 2'h0;
		end
		else if (wr && addr == timer8_pkg::ADDR_COUNT)
		begin
			counter_value <= wdata;
			match_block <= 2'h3;
		end
		else if (tick)
		begin
			counter_value <= next_count;
			count_down <= next_down;
			match_block <= 2'h0;
		end
	end

	// Software writes land in a shadow; live values follow per the mode's update point.
	always_ff @(posedge mclk)
	begin
		if (rst)
		begin
			cmp_buf_a <= timer8_pkg::RESET_BYTE;
			cmp_buf_b <= timer8_pkg::RESET_BYTE;
			chan_a_compare_value <= timer8_pkg::RESET_BYTE;
			chan_b_compare_value <= timer8_pkg::RESET_BYTE;
		end
		else
		begin
			if (wr && addr == timer8_pkg::ADDR_CMP_A)
			begin
				cmp_buf_a <= wdata;
			end
			if (wr && addr == timer8_pkg::ADDR_CMP_B)
			begin
				cmp_buf_b <= wdata;
			end
			if (non_pwm || (tick && ((fast_pwm && at_top) || (phase_pwm && at_top && !count_down))))
			begin
				chan_a_compare_value <= cmp_buf_a;
				chan_b_compare_value <= cmp_buf_b;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// One output unit per channel; channel B treats code 01 in PWM as reserved (level held, pin still driven).
	genvar ch;
	generate
		for (ch = 0; ch < 2; ch = ch + 1)
		begin : g_chan
			logic [1:0] md;
			logic [7:0] cmp;
			logic match;
			logic at_end;
			logic special;
			logic next_out;
			assign md = (ch == 0) ? mode_a : mode_b;
			assign cmp = (ch == 0) ? chan_a_compare_value : chan_b_compare_value;
			assign match = events[(ch == 0) ? timer8_pkg::EVT_MATCH_A : timer8_pkg::EVT_MATCH_B];
			assign special = md[1] && (cmp == top);
			assign at_end = fast_pwm ? (at_top) : (at_top && !count_down);
			always_comb
			begin
				next_out = wave_out[ch];
				if (non_pwm)
				begin
					if (match)
					begin
						case (md)
							timer8_pkg::OUT_TOGGLE: next_out = ~wave_out[ch];
							timer8_pkg::OUT_CLEAR: next_out = 1'b0;
							timer8_pkg::OUT_SET: next_out = 1'b1;
							default: next_out = wave_out[ch];
						endcase
					end
				end
				else if (fast_pwm || phase_pwm)
				begin
					if (md == timer8_pkg::OUT_TOGGLE)
					begin
						if (ch == 0 && waveform_mode_select[2] && match)
						begin
							next_out = ~wave_out[ch];
						end
					end
					else if (md[1] && fast_pwm)
					begin
						// Wrap to BOTTOM restores the idle level; a TOP compare acts there only.
						if (at_top)
						begin
							next_out = ~md[0];
						end
						else if (match && !special)
						begin
							next_out = md[0];
						end
					end
					else if (md[1])
					begin
						if (special)
						begin
							if (at_end)
							begin
								next_out = ~md[0];
							end
						end
						else if (match)
						begin
							next_out = count_down ? ~md[0] : md[0];
						end
					end
				end
			end
			always_ff @(posedge mclk)
			begin
				if (rst)
				begin
					wave_out[ch] <= 1'b0;
				end
				else if (tick)
				begin
					wave_out[ch] <= next_out;
				end
			end
		end
	endgenerate

	// Pins: connected only when the channel's mode code is nonzero and its direction bit is set.
	always_ff @(posedge mclk)
	begin
		if (rst)
		begin
			chan_a_compare_pin <= 1'b0;
			chan_b_compare_pin <= 1'b0;
			chan_a_compare_pin_oe_n <= 1'b1;
			chan_b_compare_pin_oe_n <= 1'b1;
		end
		else
		begin
			chan_a_compare_pin <= wave_out[0];
			chan_b_compare_pin <= wave_out[1];
			chan_a_compare_pin_oe_n <= ~((mode_a != timer8_pkg::OUT_OFF) && pin_dir[0]);
			chan_b_compare_pin_oe_n <= ~((mode_b != timer8_pkg::OUT_OFF) && pin_dir[1]);
		end
	end

	////////////////////////////////////////////////////////////////////////////
	always_ff @(posedge mclk)
	begin
		if (rst)
		begin
			waveform_control_a <= timer8_pkg::RESET_BYTE;
			waveform_control_b <= timer8_pkg::RESET_BYTE;
			mask <= 3'h0;
			pin_dir <= 2'h0;
		end
		else if (wr)
		begin
			case (addr)
				timer8_pkg::ADDR_CTRL_A: waveform_control_a <= wdata & timer8_pkg::CTRL_A_WRITE_MASK;
				timer8_pkg::ADDR_CTRL_B: waveform_control_b <= wdata & timer8_pkg::CTRL_B_WRITE_MASK;
				timer8_pkg::ADDR_MASK: mask <= wdata[2:0];
				timer8_pkg::ADDR_DIR: pin_dir <= wdata[1:0];
				default: mask <= mask;
			endcase
		end
	end

	// Sticky events; a status read clears them, but a same-cycle event survives.
	always_ff @(posedge mclk)
	begin
		if (rst)
		begin
			status <= 3'h0;
		end
		else
		begin
			status <= ((rd && addr == timer8_pkg::ADDR_STATUS) ? 3'h0 : status)
				| (tick ? events : 3'h0);
		end
	end

	always_ff @(posedge mclk)
	begin
		if (rst)
		begin
			irq <= 1'b0;
			rdata <= 8'h00;
		end
		else
		begin
			irq <= |(status & mask);
			if (rd)
			begin
				case (addr)
					timer8_pkg::ADDR_CTRL_A: rdata <= waveform_control_a;
					timer8_pkg::ADDR_CTRL_B: rdata <= waveform_control_b;
					timer8_pkg::ADDR_COUNT: rdata <= counter_value;
					timer8_pkg::ADDR_CMP_A: rdata <= cmp_buf_a;
					timer8_pkg::ADDR_CMP_B: rdata <= cmp_buf_b;
					timer8_pkg::ADDR_STATUS: rdata <= {5'h00, status};
					timer8_pkg::ADDR_MASK: rdata <= {5'h00, mask};
					default: rdata <= {6'h00, pin_dir};
				endcase
			end
			else
			begin
				rdata <= 8'h00;
			end
		end
	end
endmodule : timer8_waveform_output_control
`default_nettype wire

// ==== test/timer8_load_model.sv ====
// External load on one compare pin, with a pull-down, counting cycles at high level.
`timescale 1ns/1ps
`default_nettype none
module timer8_load_model (
	input wire logic mclk,
	input wire logic clr,
	input wire logic pin,
	input wire logic pin_oe_n,
	output logic [9:0] highs
);
	// A released pin falls to the pull-down, so only a driven high is counted.
	always_ff @(posedge mclk)
	begin
		if (clr)
			highs <= 10'h000;
		else if (!pin_oe_n && pin)
			highs <= highs + 10'h001;
	end
endmodule : timer8_load_model
`default_nettype wire

// ==== test/timer8_waveform_output_control_chk.sv ====
// Checker of readback, pin ownership, tick gating and interrupt masking at the ports.
`timescale 1ns/1ps
`default_nettype none
module timer8_waveform_output_control_chk (
	input wire logic mclk,
	input wire logic rst,
	input wire logic [2:0] addr,
	input wire logic [7:0] wdata,
	input wire logic wr,
	input wire logic rd,
	input wire logic timer_tick,
	input wire logic [7:0] rdata,
	input wire logic chan_a_compare_pin,
	input wire logic chan_a_compare_pin_oe_n,
	input wire logic chan_b_compare_pin,
	input wire logic chan_b_compare_pin_oe_n,
	input wire logic irq
);
	logic [7:0] ctl_a;
	logic [7:0] ctl_b;
	logic [7:0] dir;
	logic [7:0] msk;
	// Shadows come from the bus alone, so a lost or misdecoded write shows up.
	always_ff @(posedge mclk)
	begin
		if (rst)
		begin
			ctl_a <= 8'h00;
			ctl_b <= 8'h00;
			dir <= 8'h00;
			msk <= 8'h00;
		end
		else if (wr)
		begin
			case (addr)
				timer8_pkg::ADDR_CTRL_A: ctl_a <= wdata & timer8_pkg::CTRL_A_WRITE_MASK;
				timer8_pkg::ADDR_CTRL_B: ctl_b <= wdata & timer8_pkg::CTRL_B_WRITE_MASK;
				timer8_pkg::ADDR_DIR: dir <= wdata;
				timer8_pkg::ADDR_MASK: msk <= wdata;
				default: ;
			endcase
		end
	end
	////////////////////////////////////////
	default clocking @(posedge mclk); endclocking
	default disable iff (rst);
	sequence rd_of(logic [2:0] a);
		rd && addr == a;
	endsequence
	a_ctrl_a_readback:
		assert property (rd_of(timer8_pkg::ADDR_CTRL_A) |=> rdata == $past(ctl_a))
		else $error("control A readback differs");
	a_ctrl_b_readback:
		assert property (rd_of(timer8_pkg::ADDR_CTRL_B) |=> rdata == $past(ctl_b))
		else $error("control B readback differs");
	a_idle_rdata_zero:
		assert property (!rd |=> rdata == 8'h00)
		else $error("read data not zero outside a read");
	a_pin_a_owner:
		assert property (chan_a_compare_pin_oe_n == !((|$past(ctl_a[7:6])) && $past(dir[0])))
		else $error("channel A pin enable wrong");
	a_pin_b_owner:
		assert property (chan_b_compare_pin_oe_n == !((|$past(ctl_a[5:4])) && $past(dir[1])))
		else $error("channel B pin enable wrong");
	a_pin_a_tick:
		assert property ($changed(chan_a_compare_pin) |-> $past(timer_tick, 2))
		else $error("channel A moved without a tick");
	a_pin_b_tick:
		assert property ($changed(chan_b_compare_pin) |-> $past(timer_tick, 2))
		else $error("channel B moved without a tick");
	a_irq_masked_off:
		assert property (!(|$past(msk[2:0])) |-> !irq)
		else $error("interrupt high while all masked");
endmodule : timer8_waveform_output_control_chk
bind timer8_waveform_output_control timer8_waveform_output_control_chk chk (.mclk, .rst, .addr,
	.wdata, .wr, .rd, .timer_tick, .rdata, .chan_a_compare_pin, .chan_a_compare_pin_oe_n,
	.chan_b_compare_pin, .chan_b_compare_pin_oe_n, .irq);
`default_nettype wire

// ==== test/timer8_waveform_output_control_bench.sv ====
// Self-checking bench of the 8-bit waveform timer with a load on each compare pin.
`timescale 1ns/1ps
`default_nettype none
module timer8_waveform_output_control_bench;
	logic mclk = 1'b0;
	logic rst = 1'b1;
	logic [2:0] addr = 3'h0;
	logic [7:0] wdata = 8'h00;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic timer_tick = 1'b0;
	logic clr = 1'b0;
	logic [7:0] rdata;
	logic pa;
	logic pa_oe_n;
	logic pb;
	logic pb_oe_n;
	logic irq;
	logic [9:0] highs_a;
	logic [9:0] highs_b;
	logic [7:0] v0;
	int n_fail = 0;
	int check_count = 0;
	always #20 mclk = ~mclk;
	timer8_waveform_output_control dut (.mclk, .rst, .addr, .wdata, .wr, .rd, .timer_tick, .rdata,
		.chan_a_compare_pin(pa), .chan_a_compare_pin_oe_n(pa_oe_n), .chan_b_compare_pin(pb),
		.chan_b_compare_pin_oe_n(pb_oe_n), .irq);
	timer8_load_model load_a (.mclk, .clr, .pin(pa), .pin_oe_n(pa_oe_n), .highs(highs_a));
	timer8_load_model load_b (.mclk, .clr, .pin(pb), .pin_oe_n(pb_oe_n), .highs(highs_b));
	////////////////////////////////////////
	task automatic check(input logic [9:0] got, input logic [9:0] exp);
		check_count++;
		if (got !== exp)
		begin
			n_fail++;
			$display("[FAIL] %0t got %h exp %h", $time, got, exp);
		end
	endtask : check
	task automatic finish_test;
		$display("checks %0d mismatches %0d", check_count, n_fail);
		if (n_fail == 0 && check_count > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : finish_test
	task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge mclk);
		wr <= 1'b0;
		@(posedge mclk);
	endtask : wr_reg
	task automatic rd_reg(input logic [2:0] a, output logic [7:0] d);
		addr <= a;
		rd <= 1'b1;
		@(posedge mclk);
		rd <= 1'b0;
		#1;
		d = rdata;
		@(posedge mclk);
	endtask : rd_reg
	// Settling spans two slow periods so shadowed compare values are live.
	task automatic cfg(input logic [7:0] b, input logic [7:0] ca, input logic [7:0] cb,
		input logic [7:0] a);
		wr_reg(timer8_pkg::ADDR_CTRL_B, b);
		wr_reg(timer8_pkg::ADDR_CMP_A, ca);
		wr_reg(timer8_pkg::ADDR_CMP_B, cb);
		wr_reg(timer8_pkg::ADDR_CTRL_A, a);
		repeat (1100) @(posedge mclk);
	endtask : cfg
	// Any whole number of periods gives the same high count, whatever the phase.
	task automatic measure(input int n, input logic [9:0] ea, input logic [9:0] eb);
		clr <= 1'b1;
		@(posedge mclk);
		clr <= 1'b0;
		repeat (n) @(posedge mclk);
		#1;
		check(highs_a, ea);
		check(highs_b, eb);
	endtask : measure
	task automatic t_fast;
		cfg(8'h01, 8'h40, 8'h80, 8'hb3);
		measure(256, 10'h041, 10'h07f);
	endtask : t_fast
	task automatic t_phase;
		cfg(8'h01, 8'h30, 8'h50, 8'hb1);
		measure(510, 10'h060, 10'h15e);
	endtask : t_phase
	task automatic t_ctc;
		cfg(8'h01, 8'h09, 8'h03, 8'h52);
		measure(20, 10'h00a, 10'h00a);
	endtask : t_ctc
	task automatic t_top;
		cfg(8'h09, 8'h14, 8'h05, 8'hb3);
		measure(42, 10'h02a, 10'h01e);
		wr_reg(timer8_pkg::ADDR_CTRL_A, 8'h73);
		repeat (100) @(posedge mclk);
		measure(42, 10'h015, 10'h01e);
	endtask : t_top
	// A compare equal to TOP in phase-correct mode must hold the non-inverting level high.
	task automatic t_pc_top;
		cfg(8'h09, 8'h10, 8'h08, 8'ha1);
		measure(64, 10'h040, 10'h020);
	endtask : t_pc_top
	task automatic t_hold;
		wr_reg(timer8_pkg::ADDR_CTRL_A, 8'hff);
		rd_reg(timer8_pkg::ADDR_CTRL_A, v0);
		check({2'h0, v0}, 10'h0f3);
		rd_reg(timer8_pkg::ADDR_CTRL_B, v0);
		check({2'h0, v0}, 10'h009);
		timer_tick <= 1'b0;
		wr_reg(timer8_pkg::ADDR_COUNT, 8'h37);
		repeat (20) @(posedge mclk);
		rd_reg(timer8_pkg::ADDR_COUNT, v0);
		check({2'h0, v0}, 10'h037);
		timer_tick <= 1'b1;
		wr_reg(timer8_pkg::ADDR_CTRL_A, 8'h00);
		wr_reg(timer8_pkg::ADDR_COUNT, 8'h5a);
		repeat (20) @(posedge mclk);
		rd_reg(timer8_pkg::ADDR_COUNT, v0);
		check({2'h0, v0}, 10'h05a);
		#1;
		check({9'h000, pa_oe_n}, 10'h001);
	endtask : t_hold
	task automatic t_irq;
		int i;
		wr_reg(timer8_pkg::ADDR_CTRL_B, 8'h01);
		rd_reg(timer8_pkg::ADDR_STATUS, v0);
		wr_reg(timer8_pkg::ADDR_MASK, 8'h01);
		for (i = 0; i < 300; i++)
		begin
			@(posedge mclk);
			#1;
			if (irq === 1'b1)
				break;
		end
		check({9'h000, irq}, 10'h001);
		if (irq !== 1'b1)
			finish_test();
		rd_reg(timer8_pkg::ADDR_STATUS, v0);
		check({9'h000, v0[timer8_pkg::EVT_OVERFLOW]}, 10'h001);
		@(posedge mclk);
		#1;
		check({9'h000, irq}, 10'h000);
		wr_reg(timer8_pkg::ADDR_MASK, 8'h00);
	endtask : t_irq
	////////////////////////////////////////
	initial
	begin
		repeat (2) @(posedge mclk);
		rst <= 1'b0;
		timer_tick <= 1'b1;
		wr_reg(timer8_pkg::ADDR_DIR, 8'h03);
		t_fast();
		t_phase();
		t_ctc();
		t_top();
		t_pc_top();
		t_hold();
		t_irq();
		finish_test();
	end
endmodule : timer8_waveform_output_control_bench
`default_nettype wire
